// >>> shared/nec_defs.svh
// Purpose: constants of the numeric exception and init unit
// Assumes: 16-bit control, status and tag words
// Notes:   field positions are bit indexes within those words, except NEC_CC_ONE, an index within C3..C0
//
// Functional notes
// - unmasked exception sets flag, summary, error line
// - only waiting escapes see error; nowait never
// - keep instruction and operand address per numeric escape
// - six exceptions in fixed precedence order
// - invalid: snan, unsupported, indeterminate, stack fault
// - denormal operand flagged; masked means normalize
// - zero divisor with finite nonzero dividend
// - overflow gives largest finite or infinity
// - masked underflow flagged only on accuracy loss
// - inexact rounds per mode, flagged, continues
// - reset or init loads control word 037F
// - infinity bit kept for readback only; affine always
// - init clears flags, top, busy bit
// - condition codes cleared on init, incomplete remainder
// - reset or init sets tag word FFFF
// - legacy irq enable/disable ops change nothing
// - tag writes cannot contradict register contents
// - load constant rounds; pseudo encodings unsupported
// - control bits five to zero mask exceptions
// - stack fault: bit one gives overflow direction
// - dedicated active-low error line to host
`ifndef NEC_DEFS_SVH
`define NEC_DEFS_SVH

`define NEC_CW_INIT   16'h037F
`define NEC_TW_INIT   16'hFFFF
`define NEC_CW_INF    12
`define NEC_CW_RC_HI  11
`define NEC_CW_RC_LO  10
`define NEC_SW_BUSY   15
`define NEC_SW_SUM    7
`define NEC_SW_STKF   6
`define NEC_EXC_INV   0
`define NEC_EXC_DE    1
`define NEC_EXC_ZE    2
`define NEC_EXC_OE    3
`define NEC_EXC_UE    4
`define NEC_EXC_PE    5
`define NEC_CC_ONE    1
`define NEC_TAG_EMPTY 2'h3

`endif

// >>> shared/nec_pkg.sv
// Purpose: types of the numeric exception and init unit
// Assumes: 20-bit host addresses
// Notes:   command and report travel as packed structs
package nec_pkg;

  typedef enum logic [3:0] {
    NEC_OP_ARITH, NEC_OP_LOAD_CONST, NEC_OP_PREM, NEC_OP_NULL,
    NEC_OP_INIT_NOWAIT, NEC_OP_INIT_WAIT, NEC_OP_CLEX_NOWAIT,
    NEC_OP_STSW_NOWAIT, NEC_OP_STENV_NOWAIT, NEC_OP_SAVE_NOWAIT,
    NEC_OP_LEG_EN, NEC_OP_LEG_EN_NOWAIT, NEC_OP_LEG_DIS,
    NEC_OP_LEG_DIS_NOWAIT
  } nec_op_t;

  typedef enum logic [1:0] {NEC_FMT_REAL, NEC_FMT_INT, NEC_FMT_BCD}
    nec_fmt_t;

  typedef enum logic [3:0] {
    NEC_RSP_NONE, NEC_RSP_QNAN, NEC_RSP_INT_INDEF, NEC_RSP_BCD_INDEF,
    NEC_RSP_NORMALIZE, NEC_RSP_INF, NEC_RSP_LARGEST, NEC_RSP_DENORM_ZERO,
    NEC_RSP_ROUNDED
  } nec_rsp_t;

  typedef struct packed {
    logic        valid;
    nec_op_t     op;
    logic [19:0] instr_addr;
    logic [19:0] oper_addr;
    logic        has_mem;
  } nec_cmd_t;

  typedef struct packed {
    logic     valid;
    logic     snan;
    logic     unsup;
    logic     pseudo;
    logic     indet;
    logic     stk_ovf;
    logic     stk_unf;
    logic     denorm;
    logic     div_zero;
    logic     dvd_fin_nz;
    logic     ovf;
    logic     tiny;
    logic     acc_loss;
    logic     inexact;
    logic     sign;
    nec_fmt_t fmt;
  } nec_rpt_t;

endpackage

// >>> logic/nec_exc_unit.sv
// Purpose: exception detect, report and init of a numeric coprocessor
// Assumes: datapath reports causes; host decodes escape class
// Notes:   all state frozen while clk_en is low
`timescale 1ns/1ps
`include "nec_defs.svh"

module nec_exc_unit (
  input  wire logic             core_clk,    // 10 MHz core clock
  input  wire logic             resetn,      // sync reset, low active
  input  wire logic             clk_en,      // freezes state when low
  input  wire nec_pkg::nec_cmd_t cmd_i,      // escape issued by host
  input  wire nec_pkg::nec_rpt_t rpt_i,      // datapath cause report
  input  wire logic             done_i,      // current op finished
  input  wire logic             cw_wr_i,     // load control word
  input  wire logic [15:0]      cw_wdata_i,  // control word value
  input  wire logic             tag_wr_i,    // load tag word
  input  wire logic [15:0]      tag_wdata_i, // tag word value
  input  wire logic [15:0]      tag_act_i,   // tags of real contents
  input  wire logic             top_wr_i,    // stack top update
  input  wire logic [2:0]       top_i,       // new stack top
  input  wire logic             cc_wr_i,     // condition code update
  input  wire logic [3:0]       cc_i,        // new C3..C0
  input  wire logic             prem_inc_i,  // remainder incomplete
  output logic [15:0]           cw_o,        // control word
  output logic [15:0]           sw_o,        // status word
  output logic [15:0]           tw_o,        // tag word
  output logic [19:0]           ip_o,        // faulting instr addr
  output logic [19:0]           dp_o,        // its operand addr
  output logic                  error_n_o,   // error line, low active
  output logic                  busy_o,      // busy to host
  output logic                  trap_chk_o,  // escape met error
  output nec_pkg::nec_rsp_t     rsp_o,       // masked default action
  output logic                  rsp_vld_o    // rsp_o valid pulse
);

  logic [15:0]       cw_q;
  logic [15:0]       cw_d;
  logic [15:0]       tw_q;
  logic [15:0]       tw_d;
  logic [5:0]        flag_q;
  logic [5:0]        flag_d;
  logic              stkf_q;
  logic              stkf_d;
  logic              sum_q;
  logic              sum_d;
  logic [3:0]        cc_q;
  logic [3:0]        cc_d;
  logic [2:0]        top_q;
  logic              busy_q;
  logic [19:0]       ip_q;
  logic [19:0]       dp_q;
  logic              err_n_q;
  logic              trap_q;
  nec_pkg::nec_rsp_t rsp_q;
  nec_pkg::nec_rsp_t rsp_d;
  logic              rsp_vld_q;

  // decoded strobes of the current cycle
  logic              init_c;
  logic              clex_c;
  logic              legacy_c;
  logic              numop_c;
  logic              chk_c;
  logic [5:0]        raw_c;
  logic [5:0]        set_c;
  logic              rpt_c;

  // waiting escapes that check the error line
  function automatic logic nec_checks(input nec_pkg::nec_op_t op);
    unique case (op)
      nec_pkg::NEC_OP_ARITH, nec_pkg::NEC_OP_LOAD_CONST,
      nec_pkg::NEC_OP_PREM, nec_pkg::NEC_OP_NULL,
      nec_pkg::NEC_OP_INIT_WAIT: nec_checks = 1'b1;
      default: nec_checks = 1'b0;
    endcase
  endfunction

  // legacy interrupt enable and disable, every form
  function automatic logic nec_legacy(input nec_pkg::nec_op_t op);
    nec_legacy = (op == nec_pkg::NEC_OP_LEG_EN) ||
                 (op == nec_pkg::NEC_OP_LEG_EN_NOWAIT) ||
                 (op == nec_pkg::NEC_OP_LEG_DIS) ||
                 (op == nec_pkg::NEC_OP_LEG_DIS_NOWAIT);
  endfunction

  // an escape with an operand that may raise an exception
  function automatic logic nec_numeric(input nec_pkg::nec_op_t op);
    nec_numeric = (op == nec_pkg::NEC_OP_ARITH) ||
                  (op == nec_pkg::NEC_OP_LOAD_CONST) ||
                  (op == nec_pkg::NEC_OP_PREM);
  endfunction

  // command decode
  always_comb begin
    init_c   = cmd_i.valid &&
               ((cmd_i.op == nec_pkg::NEC_OP_INIT_NOWAIT) ||
                (cmd_i.op == nec_pkg::NEC_OP_INIT_WAIT));
    clex_c   = cmd_i.valid && (cmd_i.op == nec_pkg::NEC_OP_CLEX_NOWAIT);
    legacy_c = cmd_i.valid && nec_legacy(cmd_i.op);
    numop_c  = cmd_i.valid && nec_numeric(cmd_i.op);
    chk_c    = cmd_i.valid && nec_checks(cmd_i.op);
    rpt_c    = rpt_i.valid;
  end

  // raw causes, before precedence
  always_comb begin
    raw_c = '0;
    raw_c[`NEC_EXC_INV] = rpt_i.snan | rpt_i.unsup | rpt_i.pseudo |
                         rpt_i.indet | rpt_i.stk_ovf |
                         rpt_i.stk_unf;
    raw_c[`NEC_EXC_DE] = rpt_i.denorm;
    raw_c[`NEC_EXC_ZE] = rpt_i.div_zero & rpt_i.dvd_fin_nz;
    raw_c[`NEC_EXC_OE] = rpt_i.ovf;
    // masked underflow only counts with loss of accuracy
    raw_c[`NEC_EXC_UE] = rpt_i.tiny &
                         (~cw_q[`NEC_EXC_UE] | rpt_i.acc_loss);
    raw_c[`NEC_EXC_PE] = rpt_i.inexact;
  end

  // precedence: pre-op faults stop the op, later ones accumulate
  always_comb begin
    set_c = '0;
    if (raw_c[`NEC_EXC_INV]) begin
      set_c[`NEC_EXC_INV] = 1'b1;
    end else if (raw_c[`NEC_EXC_DE] && !cw_q[`NEC_EXC_DE]) begin
      set_c[`NEC_EXC_DE] = 1'b1;
    end else if (raw_c[`NEC_EXC_ZE]) begin
      set_c[`NEC_EXC_ZE] = 1'b1;
      set_c[`NEC_EXC_DE] = raw_c[`NEC_EXC_DE];
    end else begin
      set_c = raw_c & 6'h3A;
    end
    if (!rpt_c) begin
      set_c = '0;
    end
  end

  // masked default response, highest precedence first
  always_comb begin
    rsp_d = nec_pkg::NEC_RSP_NONE;
    if (set_c[`NEC_EXC_INV]) begin
      if (cw_q[`NEC_EXC_INV]) begin
        unique case (rpt_i.fmt)
          nec_pkg::NEC_FMT_INT: rsp_d = nec_pkg::NEC_RSP_INT_INDEF;
          nec_pkg::NEC_FMT_BCD: rsp_d = nec_pkg::NEC_RSP_BCD_INDEF;
          default:              rsp_d = nec_pkg::NEC_RSP_QNAN;
        endcase
      end
    end else if (set_c[`NEC_EXC_DE] && !cw_q[`NEC_EXC_DE]) begin
      rsp_d = nec_pkg::NEC_RSP_NONE;
    end else if (set_c[`NEC_EXC_ZE]) begin
      if (cw_q[`NEC_EXC_ZE]) rsp_d = nec_pkg::NEC_RSP_INF;
    end else if (set_c[`NEC_EXC_OE]) begin
      if (cw_q[`NEC_EXC_OE]) begin
        // directed rounding away from the overflow stays finite
        unique case (cw_q[`NEC_CW_RC_HI:`NEC_CW_RC_LO])
          2'h0: rsp_d = nec_pkg::NEC_RSP_INF;
          2'h1: rsp_d = rpt_i.sign ? nec_pkg::NEC_RSP_INF
                                   : nec_pkg::NEC_RSP_LARGEST;
          2'h2: rsp_d = rpt_i.sign ? nec_pkg::NEC_RSP_LARGEST
                                   : nec_pkg::NEC_RSP_INF;
          2'h3:    rsp_d = nec_pkg::NEC_RSP_LARGEST;
        endcase
      end
    end else if (rpt_i.tiny && cw_q[`NEC_EXC_UE]) begin
      rsp_d = nec_pkg::NEC_RSP_DENORM_ZERO;
    end else if (set_c[`NEC_EXC_PE]) begin
      if (cw_q[`NEC_EXC_PE]) rsp_d = nec_pkg::NEC_RSP_ROUNDED;
    end else if (set_c[`NEC_EXC_DE]) begin
      rsp_d = nec_pkg::NEC_RSP_NORMALIZE;
    end
  end

  // exception flags: a new cause wins over a same-cycle clear
  always_comb begin
    flag_d = flag_q;
    stkf_d = stkf_q;
    if (init_c || clex_c) begin
      flag_d = 6'h00;
      stkf_d = 1'b0;
    end
    flag_d = flag_d | set_c;
    if (rpt_c && (rpt_i.stk_ovf || rpt_i.stk_unf)) begin
      stkf_d = 1'b1;
    end
  end

  // control word next value
  always_comb begin
    cw_d = cw_q;
    if (init_c) begin
      cw_d = `NEC_CW_INIT;
    end else if (cw_wr_i) begin
      cw_d = cw_wdata_i;
    end
  end

  // summary: any flag whose mask bit is clear
  always_comb begin
    sum_d = |(flag_d & ~cw_d[5:0]);
  end

  // condition codes with stack fault direction
  always_comb begin
    cc_d = cc_q;
    if (cc_wr_i) begin
      cc_d = cc_i;
    end
    if (rpt_c && (rpt_i.stk_ovf || rpt_i.stk_unf)) begin
      cc_d[`NEC_CC_ONE] = rpt_i.stk_ovf;
    end
    if (init_c || prem_inc_i) begin
      cc_d = 4'h0;
    end
  end

  // tag word: each entry may only be emptied or match contents
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_tag
      always_comb begin
        tw_d[2*gi+1:2*gi] = tw_q[2*gi+1:2*gi];
        if (init_c) begin
          tw_d[2*gi+1:2*gi] = `NEC_TAG_EMPTY;
        end else if (tag_wr_i) begin
          tw_d[2*gi+1:2*gi] =
            (tag_wdata_i[2*gi+1:2*gi] == `NEC_TAG_EMPTY) ?
            `NEC_TAG_EMPTY : tag_act_i[2*gi+1:2*gi];
        end
      end
    end
  endgenerate

  // control and tag words
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cw_q <= `NEC_CW_INIT;
      tw_q <= `NEC_TW_INIT;
    end else if (clk_en) begin
      cw_q <= cw_d;
      tw_q <= tw_d;
    end
  end

  // status word fields
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flag_q <= 6'h00;
      stkf_q <= 1'b0;
      sum_q  <= 1'b0;
      cc_q   <= 4'h0;
    end else if (clk_en) begin
      flag_q <= flag_d;
      stkf_q <= stkf_d;
      sum_q  <= sum_d;
      cc_q   <= cc_d;
    end
  end

  // stack top pointer; init puts first push at register seven
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      top_q <= 3'h0;
    end else if (clk_en) begin
      if (init_c) begin
        top_q <= 3'h0;
      end else if (top_wr_i) begin
        top_q <= top_i;
      end
    end
  end

  // busy: raised per numeric escape, dropped on completion or init
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (init_c) begin
        busy_q <= 1'b0;
      end else if (numop_c) begin
        busy_q <= 1'b1;
      end else if (done_i) begin
        busy_q <= 1'b0;
      end
    end
  end

  // pointers kept so a handler can find the faulting escape
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ip_q <= 20'h00000;
      dp_q <= 20'h00000;
    end else if (clk_en && numop_c) begin
      ip_q <= cmd_i.instr_addr;
      if (cmd_i.has_mem) begin
        dp_q <= cmd_i.oper_addr;
      end
    end
  end

  // error line, dedicated and low active
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      err_n_q <= 1'b1;
    end else if (clk_en) begin
      err_n_q <= ~sum_d;
    end
  end

  // escape that samples a pending error; host takes its trap
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      trap_q <= 1'b0;
    end else if (clk_en) begin
      trap_q <= chk_c && !legacy_c && !err_n_q;
    end
  end

  // masked response handed to the datapath
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rsp_q     <= nec_pkg::NEC_RSP_NONE;
      rsp_vld_q <= 1'b0;
    end else if (clk_en) begin
      rsp_q     <= rpt_c ? rsp_d : nec_pkg::NEC_RSP_NONE;
      rsp_vld_q <= rpt_c;
    end
  end

  // infinity bit is kept for readback only; arithmetic is affine
  assign cw_o       = cw_q;
  assign sw_o       = {busy_q, cc_q[3], top_q, cc_q[2:0], sum_q, stkf_q,
                       flag_q};
  assign tw_o       = tw_q;
  assign ip_o       = ip_q;
  assign dp_o       = dp_q;
  assign error_n_o  = err_n_q;
  assign busy_o     = busy_q;
  assign trap_chk_o = trap_q;
  assign rsp_o      = rsp_q;
  assign rsp_vld_o  = rsp_vld_q;

endmodule

// >>> sim/nec_exc_unit_chk.sv
// Purpose: port checks of the numeric exception unit
// Assumes: one clock domain, sync active-low reset
// Notes:   bound to the unit from the bench top
`timescale 1ns/1ps
module nec_exc_unit_chk (
  input wire logic              core_clk,    // clock
  input wire logic              resetn,      // reset
  input wire logic              clk_en,      // run
  input wire nec_pkg::nec_cmd_t cmd_i,       // escape
  input wire nec_pkg::nec_rpt_t rpt_i,       // causes
  input wire logic              done_i,      // op done
  input wire logic              cw_wr_i,     // cw load
  input wire logic [15:0]       cw_wdata_i,  // cw value
  input wire logic              tag_wr_i,    // tag load
  input wire logic [15:0]       tag_wdata_i, // tag value
  input wire logic [15:0]       tag_act_i,   // real tags
  input wire logic              top_wr_i,    // top load
  input wire logic [2:0]        top_i,       // top value
  input wire logic              cc_wr_i,     // cc load
  input wire logic [3:0]        cc_i,        // cc value
  input wire logic              prem_inc_i,  // remainder
  input wire logic [15:0]       cw_o,        // control
  input wire logic [15:0]       sw_o,        // status
  input wire logic [15:0]       tw_o,        // tags
  input wire logic [19:0]       ip_o,        // instr ptr
  input wire logic [19:0]       dp_o,        // data ptr
  input wire logic              error_n_o,   // error
  input wire logic              busy_o,      // busy
  input wire logic              trap_chk_o,  // trap
  input wire nec_pkg::nec_rsp_t rsp_o,       // action
  input wire logic              rsp_vld_o    // action valid
);
  // command classes; checking ops are all the rest
  wire go    = cmd_i.valid && clk_en;
  wire quiet = !(rpt_i.valid || done_i || cw_wr_i || tag_wr_i || top_wr_i
                 || cc_wr_i || prem_inc_i);
  wire no_ck = cmd_i.op inside {nec_pkg::NEC_OP_INIT_NOWAIT,
    nec_pkg::NEC_OP_CLEX_NOWAIT, nec_pkg::NEC_OP_STSW_NOWAIT,
    nec_pkg::NEC_OP_STENV_NOWAIT, nec_pkg::NEC_OP_SAVE_NOWAIT};
  wire leg   = cmd_i.op inside {nec_pkg::NEC_OP_LEG_EN,
    nec_pkg::NEC_OP_LEG_EN_NOWAIT, nec_pkg::NEC_OP_LEG_DIS,
    nec_pkg::NEC_OP_LEG_DIS_NOWAIT};
  wire init  = go && !rpt_i.valid && (cmd_i.op == nec_pkg::NEC_OP_INIT_NOWAIT
               || cmd_i.op == nec_pkg::NEC_OP_INIT_WAIT);
  // zero divide with no invalid cause beside it, so only an unmasked denormal can outrank it
  wire only_ze = rpt_i.valid && clk_en && rpt_i.div_zero && rpt_i.dvd_fin_nz
    && !(rpt_i.snan || rpt_i.unsup || rpt_i.pseudo || rpt_i.indet
    || rpt_i.stk_ovf || rpt_i.stk_unf);

  // every entry is empty or matches the real contents
  function automatic logic tags_ok(input logic [15:0] tw, act);
    tags_ok = 1'b1;
    for (int k = 0; k < 16; k += 2)
      if (tw[k+:2] != 2'h3 && tw[k+:2] != act[k+:2]) tags_ok = 1'b0;
  endfunction

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_err_level: assert property (error_n_o == !sw_o[7])
    else $error("error line differs from summary bit");
  chk_es_masks: assert property (
    sw_o[7] == |(sw_o[5:0] & ~cw_o[5:0]))
    else $error("summary bit differs from unmasked flags");
  chk_init_words: assert property (
    init |=> cw_o == 16'h037F
    && tw_o == 16'hFFFF && sw_o == 16'h0000 && error_n_o)
    else $error("init left wrong word values");
  chk_nowait_trap: assert property (
    go && (no_ck || leg) |=> !trap_chk_o)
    else $error("non-checking op raised trap");
  chk_err_trap: assert property (
    go && !no_ck && !leg && !error_n_o
    |=> trap_chk_o)
    else $error("checking op missed pending error");
  chk_ptr_keep: assert property (go && cmd_i.op == nec_pkg::NEC_OP_ARITH
    && cmd_i.has_mem |=> ip_o == $past(cmd_i.instr_addr)
    && dp_o == $past(cmd_i.oper_addr))
    else $error("pointers not captured");
  chk_legacy_idle: assert property (
    go && leg && quiet |=> $stable(cw_o)
    && $stable(sw_o) && $stable(tw_o) && $stable(ip_o) && $stable(dp_o))
    else $error("legacy op changed state");
  chk_clear_exc: assert property (go && !rpt_i.valid
    && cmd_i.op == nec_pkg::NEC_OP_CLEX_NOWAIT |=> sw_o[7:0] == 8'h00
    && error_n_o)
    else $error("clear left flags or error");
  chk_tag_real: assert property (tag_wr_i && clk_en && !go
    |=> tags_ok(tw_o, $past(tag_act_i)))
    else $error("tag entry contradicts contents");
  chk_stack_dir: assert property (
    rpt_i.valid && clk_en && rpt_i.stk_ovf
    && !go && !cc_wr_i && !prem_inc_i |=> sw_o[0] && sw_o[6] && sw_o[9])
    else $error("stack overflow bits wrong");
  chk_unmasked_ze: assert property (
    only_ze && !cw_o[2] && !go && !cw_wr_i
    |=> sw_o[2] && sw_o[7] && !error_n_o && rsp_vld_o)
    else $error("unmasked zero divide not reported");
endmodule

// >>> sim/nec_host_model.sv
// Purpose: host cpu issuing escapes to the exception unit
// Assumes: called from falling-edge bench code
// Notes:   counts numeric traps; a stuck busy is counted
`timescale 1ns/1ps
module nec_host_model (
  input  wire logic         core_clk, // clock
  input  wire logic         busy,     // unit busy
  input  wire logic         trap_chk, // escape met error
  output nec_pkg::nec_cmd_t cmd       // escape out
);
  int         traps = 0;
  int         stalls = 0;
  logic [7:0] vec_q = 8'h00;

  // an escape that meets the error takes the numeric vector
  always @(posedge core_clk) begin
    if (trap_chk) begin
      traps <= traps + 1;
      vec_q <= 8'h10;
    end
  end

  initial cmd = '0;

  // no explicit wait op: busy is polled before each escape
  task automatic issue(input nec_pkg::nec_op_t op, input logic [19:0] ia, da);
    int n;
    n = 0;
    while (busy && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (busy) stalls++;
    cmd <= '{1'b1, op, ia, da, da != 20'h0};
    @(negedge core_clk);
    cmd <= '0;
  endtask
endmodule

// >>> sim/nec_exc_unit_tb.sv
// Purpose: directed bench of the numeric exception unit
// Assumes: host model issues escapes; bench plays the datapath
// Notes:   inputs move on falling edges only
`timescale 1ns/1ps
module nec_exc_unit_tb;
  logic              core_clk = 1'b0;
  logic              resetn = 1'b0;
  logic              clk_en = 1'b1;
  nec_pkg::nec_cmd_t cmd_i;
  nec_pkg::nec_rpt_t rpt_i = '0;
  logic              done_i = 1'b0;
  logic              cw_wr_i = 1'b0;
  logic              tag_wr_i = 1'b0;
  logic              top_wr_i = 1'b0;
  logic              cc_wr_i = 1'b0;
  logic              prem_inc_i = 1'b0;
  logic [15:0]       cw_wdata_i = 16'h0000;
  logic [15:0]       tag_wdata_i = 16'h0000;
  logic [15:0]       tag_act_i = 16'h0000;
  logic [2:0]        top_i = 3'h0;
  logic [3:0]        cc_i = 4'h0;
  logic [15:0]       cw_o, sw_o, tw_o;
  logic [19:0]       ip_o, dp_o;
  logic              error_n_o, busy_o, trap_chk_o, rsp_vld_o;
  nec_pkg::nec_rsp_t rsp_o;
  int                mismatches = 0;
  int                num_checks = 0;
  // masked cases: causes, low status bits and default action
  logic [12:0]       cz [14] = '{13'h1000, 13'h0800, 13'h0200, 13'h0400,
    13'h0100, 13'h0080, 13'h0040, 13'h0030, 13'h0020, 13'h0008, 13'h0006,
    13'h0004, 13'h0001, 13'h1030};
  logic [7:0]        sx [14] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h41, 8'h41,
    8'h02, 8'h04, 8'h00, 8'h08, 8'h10, 8'h00, 8'h20, 8'h01};
  nec_pkg::nec_rsp_t rx [14] = '{nec_pkg::NEC_RSP_QNAN,
    nec_pkg::NEC_RSP_INT_INDEF, nec_pkg::NEC_RSP_BCD_INDEF,
    nec_pkg::NEC_RSP_QNAN, nec_pkg::NEC_RSP_QNAN, nec_pkg::NEC_RSP_QNAN,
    nec_pkg::NEC_RSP_NORMALIZE, nec_pkg::NEC_RSP_INF, nec_pkg::NEC_RSP_NONE,
    nec_pkg::NEC_RSP_INF, nec_pkg::NEC_RSP_DENORM_ZERO,
    nec_pkg::NEC_RSP_DENORM_ZERO, nec_pkg::NEC_RSP_ROUNDED,
    nec_pkg::NEC_RSP_QNAN};

  always #50 core_clk = ~core_clk;

  nec_exc_unit nec_exc_unit_i (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .cmd_i(cmd_i),
    .rpt_i(rpt_i), .done_i(done_i), .cw_wr_i(cw_wr_i), .cw_wdata_i(cw_wdata_i),
    .tag_wr_i(tag_wr_i), .tag_wdata_i(tag_wdata_i), .tag_act_i(tag_act_i),
    .top_wr_i(top_wr_i), .top_i(top_i), .cc_wr_i(cc_wr_i), .cc_i(cc_i),
    .prem_inc_i(prem_inc_i), .cw_o(cw_o), .sw_o(sw_o), .tw_o(tw_o),
    .ip_o(ip_o), .dp_o(dp_o), .error_n_o(error_n_o), .busy_o(busy_o),
    .trap_chk_o(trap_chk_o), .rsp_o(rsp_o), .rsp_vld_o(rsp_vld_o));

  nec_host_model host_i (
    .core_clk(core_clk), .busy(busy_o), .trap_chk(trap_chk_o), .cmd(cmd_i));

  task automatic check(input string nm, input logic [19:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one-cycle datapath report; answer is visible on return
  task automatic report(input logic [12:0] c, input nec_pkg::nec_fmt_t f,
                        input logic s);
    rpt_i = {1'b1, c, s, f};
    tick(1);
    rpt_i = '0;
  endtask

  // escape, then finish it so busy drops before the next one
  task automatic op(input nec_pkg::nec_op_t o, input logic [19:0] ia, da);
    host_i.issue(o, ia, da);
    done_i = 1'b1;
    tick(1);
    done_i = 1'b0;
  endtask

  task automatic cwrite(input logic [15:0] v);
    cw_wdata_i = v;
    cw_wr_i = 1'b1;
    tick(1);
    cw_wr_i = 1'b0;
  endtask

  // hang guard: a run this long means something stuck
  initial begin
    tick(5000);
    mismatches++;
    complete_run();
  end

  initial begin
    tick(20);
    resetn = 1'b1;
    tick(1);
    check("cw", cw_o, 20'h0037F);
    check("sw", sw_o, 20'h00000);
    check("tw", tw_o, 20'h0FFFF);
    op(nec_pkg::NEC_OP_INIT_NOWAIT, 20'h00000, 20'h00000);
    // all masked: flag per counting cause, no error, default action per cause
    for (int i = 0; i < 14; i++) begin
      report(cz[i], i == 1 ? nec_pkg::NEC_FMT_INT : i == 2 ?
             nec_pkg::NEC_FMT_BCD : nec_pkg::NEC_FMT_REAL, 1'b0);
      check("flags", sw_o[7:0], sx[i]);
      check("rsp", rsp_o, rx[i]);
      check("rsp_vld", rsp_vld_o, 1'b1);
      check("err_n", error_n_o, 1'b1);
      op(nec_pkg::NEC_OP_CLEX_NOWAIT, 20'h00000, 20'h00000);
    end
    // masked overflow in every rounding mode and sign
    for (int m = 0; m < 8; m++) begin
      cwrite(16'h037F | (16'(m[2:1]) << 10));
      report(13'h0008, nec_pkg::NEC_FMT_REAL, m[0]);
      check("ovf_rsp", rsp_o, (m[2:1] == 2'h3 || m == 2 || m == 5) ?
            nec_pkg::NEC_RSP_LARGEST : nec_pkg::NEC_RSP_INF);
      op(nec_pkg::NEC_OP_CLEX_NOWAIT, 20'h00000, 20'h00000);
    end
    tag_act_i = 16'h5A96;
    tag_wdata_i = 16'h0F30;
    tag_wr_i = 1'b1;
    tick(1);
    tag_wr_i = 1'b0;
    check("tw", tw_o, 20'h05FB6);
    top_i = 3'h5;
    cc_i = 4'hF;
    top_wr_i = 1'b1;
    cc_wr_i = 1'b1;
    tick(1);
    top_wr_i = 1'b0;
    cc_wr_i = 1'b0;
    check("sw_cc", sw_o[14:8], 7'h6F);
    prem_inc_i = 1'b1;
    tick(1);
    prem_inc_i = 1'b0;
    check("sw_cc", sw_o[14:8], 7'h28);
    cwrite(16'h1F40);
    op(nec_pkg::NEC_OP_INIT_NOWAIT, 20'h00000, 20'h00000);
    check("cw", cw_o, 20'h0037F);
    check("sw", sw_o, 20'h00000);
    check("tw", tw_o, 20'h0FFFF);
    // unmasked zero divide during a memory-operand op
    cwrite(16'h037B);
    host_i.issue(nec_pkg::NEC_OP_ARITH, 20'h1A2B3, 20'h4C5D6);
    check("busy", busy_o, 1'b1);
    report(13'h0030, nec_pkg::NEC_FMT_REAL, 1'b0);
    check("sw", sw_o[7:0], 8'h84);
    check("err_n", error_n_o, 1'b0);
    check("ip", ip_o, 20'h1A2B3);
    check("dp", dp_o, 20'h4C5D6);
    done_i = 1'b1;
    tick(1);
    done_i = 1'b0;
    check("busy", busy_o, 1'b0);
    // store, save and legacy ops ignore the pending error
    for (int k = 7; k < 14; k++)
      op(nec_pkg::nec_op_t'(k), 20'h00000, 20'h00000);
    check("traps", host_i.traps, 20'h00000);
    check("sw", sw_o[7:0], 8'h84);
    check("cw", cw_o, 20'h0037B);
    // load constant, remainder and null op each trap
    for (int k = 1; k < 4; k++)
      op(nec_pkg::nec_op_t'(k), 20'h00000, 20'h00000);
    check("traps", host_i.traps, 20'h00003);
    check("vector", host_i.vec_q, 20'h00010);
    check("ip", ip_o, 20'h00000);
    check("dp", dp_o, 20'h4C5D6);
    op(nec_pkg::NEC_OP_CLEX_NOWAIT, 20'h00000, 20'h00000);
    check("err_n", error_n_o, 1'b1);
    check("traps", host_i.traps, 20'h00003);
    check("stalls", host_i.stalls, 20'h00000);
    // waiting init samples the pending error before clearing it
    cwrite(16'h037B);
    report(13'h0030, nec_pkg::NEC_FMT_REAL, 1'b0);
    check("err_n", error_n_o, 1'b0);
    op(nec_pkg::NEC_OP_INIT_WAIT, 20'h00000, 20'h00000);
    check("traps", host_i.traps, 20'h00004);
    check("err_n", error_n_o, 1'b1);
    check("cw", cw_o, 20'h0037F);
    // low clock enable holds every flop, so the report is lost
    clk_en = 1'b0;
    report(13'h1000, nec_pkg::NEC_FMT_REAL, 1'b0);
    clk_en = 1'b1;
    check("sw", sw_o, 20'h00000);
    check("rsp_vld", rsp_vld_o, 1'b0);
    complete_run();
  end
endmodule

bind nec_exc_unit nec_exc_unit_chk nec_exc_unit_chk_i (
  .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .cmd_i(cmd_i),
  .rpt_i(rpt_i), .done_i(done_i), .cw_wr_i(cw_wr_i), .cw_wdata_i(cw_wdata_i),
  .tag_wr_i(tag_wr_i), .tag_wdata_i(tag_wdata_i), .tag_act_i(tag_act_i),
  .top_wr_i(top_wr_i), .top_i(top_i), .cc_wr_i(cc_wr_i), .cc_i(cc_i),
  .prem_inc_i(prem_inc_i), .cw_o(cw_o), .sw_o(sw_o), .tw_o(tw_o),
  .ip_o(ip_o), .dp_o(dp_o), .error_n_o(error_n_o), .busy_o(busy_o),
  .trap_chk_o(trap_chk_o), .rsp_o(rsp_o), .rsp_vld_o(rsp_vld_o));
